// File: include/symcnt_consts.svh
// constants for the symbol counter block: offsets, field positions, reset values, timing
`ifndef SYMCNT_CONSTS_SVH
`define SYMCNT_CONSTS_SVH
// printed offsets are not word aligned, so each is an index; byte address = 4 * index
`define IDX_CNT0      8'hd0
`define IDX_CNT1      8'hd1
`define IDX_CNT2      8'he3
`define IDX_CNT3      8'hd3
`define IDX_FST0      8'he9
`define IDX_FST1      8'hea
`define IDX_FST2      8'heb
`define IDX_FST3      8'hec
`define IDX_BST0      8'hd4
`define IDX_BST1      8'hd5
`define IDX_BST2      8'hd6
`define IDX_BST3      8'hd7
`define IDX_M1B0      8'hf5
`define IDX_M1B1      8'hf6
`define IDX_M1B2      8'hf7
`define IDX_M1B3      8'hf8
`define IDX_M2B0      8'hd8
`define IDX_M3B0      8'hdc
`define IDX_CTRL      8'hc0
`define IDX_STAT      8'hc1
`define IDX_IRQS      8'hc2
`define IDX_IRQM      8'hc3
`define IDX_NETID     8'hc4
// control register bit positions
`define CTRL_REALIGN  7
`define CTRL_MANBCN   6
`define CTRL_EN       5
`define CTRL_TSE      3
// interrupt bit positions (compare units occupy bits 0..2)
`define IRQ_OVF       3
`define IRQ_BACKOFF   4
`define IRQ_W         5
// reset values
`define RST_BYTE      8'h00
`define RST_WORD      32'h0000_0000
`define NETID_BCAST   16'hffff
// timing
`define SYMBOL_NS     16000
`define CLK_NS        5
`define BACKOFF_SYMS  20
// AXI responses
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10
`endif

// File: include/symcnt_pkg.sv
// types shared by the symbol counter block
package symcnt_pkg;
  typedef struct packed {
    logic        sfd;       // start-of-frame delimiter received, length valid
    logic        frame_end; // end of received frame
    logic        beacon_ok; // frame was a beacon with valid check sequence
    logic [15:0] src_id;    // source network identifier of that frame
  } rx_evt_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_WAIT = 3'b100
  } bus_st_t;

  typedef struct packed {
    logic [31:0]      cnt;
    logic [31:0]      fstamp;
    logic [31:0]      bstamp;
    logic [2:0][31:0] match;
    logic [7:0]       ctrl;
    logic [15:0]      netid;
    logic [23:0]      cnt_stage;   // upper bytes staged until the symbol edge after the low byte write
    logic             pending;
    logic [15:0]      presc;
    logic [4:0]       slot;
    logic [4:0]       irqs;
    logic [4:0]       irqm;
    logic [2:0]       match_d;
    logic [3:0]       sync;        // second and third synchroniser stages for sfd and frame end
    logic             sfd_d;
    logic             end_d;
    bus_st_t          wst;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } state_t;
endpackage

// File: rtl/symbol_counter.sv
// symbol counter with timestamps, compare units and AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "symcnt_consts.svh"

// Summary of operation
// - 32-bit count in four read-write byte registers, high to low, reset zero
// - read-only 32-bit frame stamp in four byte registers, reset zero
// - copy frame stamp to beacon stamp for beacon with matching or broadcast id
// - beacon stamp visible as four byte registers, high to low
// - three 32-bit compare values, each four read-write byte registers, reset zero
// - writing realign bit one clears symbol prescaler and backoff slot counter
// - realign lines symbol timing up and restarts a full backoff period
// - count written high byte first; low byte write loads on next counter edge
// - frame stamp takes counter when delimiter fully received
// - compare match interrupt on absolute or beacon-relative equality, per unit
// - manual capture bit stores counter in beacon stamp, then clears itself
module symbol_counter #(
  parameter int PRESC_CYC = `SYMBOL_NS / `CLK_NS
) (
  input  wire logic                 SYS_CLK,       // 200 MHz clock
  input  wire logic                 RST,           // async reset, active high
  input  wire symcnt_pkg::rx_evt_t  RX_EVT,        // receive events from radio (async pins)
  input  wire logic [31:0]          AWADDR,        // write address
  input  wire logic                 AWVALID,       // write address valid
  output logic                      AWREADY,       // write address ready
  input  wire logic [31:0]          WDATA,         // write data
  input  wire logic [3:0]           WSTRB,         // write strobes
  input  wire logic                 WVALID,        // write data valid
  output logic                      WREADY,        // write data ready
  output logic [1:0]                BRESP,         // write response
  output logic                      BVALID,        // write response valid
  input  wire logic                 BREADY,        // write response ready
  input  wire logic [31:0]          ARADDR,        // read address
  input  wire logic                 ARVALID,       // read address valid
  output logic                      ARREADY,       // read address ready
  output logic [31:0]               RDATA,         // read data
  output logic [1:0]                RRESP,         // read response
  output logic                      RVALID,        // read data valid
  input  wire logic                 RREADY,        // read data ready
  output logic                      IRQ            // level interrupt
);
  symcnt_pkg::state_t s_r, s_nxt;
  logic [1:0] rx_s1_r;     // first synchroniser stage, read only by s_r.sync
  logic [15:0] src_id_s1_r;    // first stage, read only by src_id_r
  logic        beacon_ok_s1_r; // first stage, read only by beacon_ok_r
  logic [15:0] src_id_r;
  logic beacon_ok_r;

  ////////////////////////////////////////////////////////////////////////////
  // index decode used by read and write paths
  function automatic logic [7:0] reg_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  // byte-register fields of a 32-bit word, picked by lane 0..3
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
    return w[8*k +: 8];
  endfunction

  function automatic logic [31:0] set_byte(input logic [31:0] w, input logic [1:0] k,
                                           input logic [7:0] b);
    logic [31:0] t;
    t = w;
    t[8*k +: 8] = b;
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // first stage of the pin synchronisers; the second and third live in the state struct
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rx_s1_r <= 2'h0;
    end else begin
      rx_s1_r <= {RX_EVT.frame_end, RX_EVT.sfd};
    end
  end

  // beacon attributes pass two flops, one fewer than the strobes; sender holds them stable past frame end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      src_id_s1_r    <= 16'h0000;
      beacon_ok_s1_r <= 1'b0;
      src_id_r       <= 16'h0000;
      beacon_ok_r    <= 1'b0;
    end else begin
      src_id_s1_r    <= RX_EVT.src_id;
      beacon_ok_s1_r <= RX_EVT.beacon_ok;
      src_id_r       <= src_id_s1_r;
      beacon_ok_r    <= beacon_ok_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic       sym_tick, sfd_pulse, end_pulse, wr_go, wr_ok, rd_go, cnt_wr;
  logic [7:0] widx, ridx;
  logic [7:0] wb;
  logic [2:0] hit;
  logic [4:0] evt;
  logic [31:0] rd_word;

  always_comb begin
    s_nxt     = s_r;
    sym_tick  = (s_r.presc == 16'(PRESC_CYC - 1));
    sfd_pulse = s_r.sync[2] & ~s_r.sfd_d;
    end_pulse = s_r.sync[3] & ~s_r.end_d;
    widx      = reg_index(AWADDR);
    ridx      = reg_index(ARADDR);
    wb        = WDATA[7:0];
    wr_go     = (s_r.wst == symcnt_pkg::BUS_IDLE) & AWVALID & WVALID;
    rd_go     = ~s_r.rvalid & ARVALID;
    cnt_wr    = wr_go & WSTRB[0] & (widx == `IDX_CNT0);
    wr_ok     = 1'b1;
    evt       = 5'h00;
    rd_word   = 32'h0000_0000;

    // synchronisers, second and third stages
    s_nxt.sync  = {s_r.sync[1:0], rx_s1_r};
    s_nxt.sfd_d = s_r.sync[2];
    s_nxt.end_d = s_r.sync[3];

    // prescaler and backoff slots run only while enabled
    if (s_r.ctrl[`CTRL_EN]) begin
      s_nxt.presc = sym_tick ? 16'h0000 : s_r.presc + 16'h0001;
      if (sym_tick) begin
        s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        evt[`IRQ_OVF] = (s_r.cnt == 32'hffff_ffff);
        s_nxt.slot = (s_r.slot == 5'(`BACKOFF_SYMS - 1)) ? 5'h00 : s_r.slot + 5'h01;
        evt[`IRQ_BACKOFF] = (s_r.slot == 5'(`BACKOFF_SYMS - 1));
      end
    end

    // staged count write lands on the next symbol edge; clock is the 200 MHz system clock
    if (s_r.pending && s_r.ctrl[`CTRL_EN] && sym_tick) begin
      s_nxt.cnt     = {s_r.cnt_stage, s_r.cnt[7:0]};
      s_nxt.pending = 1'b0;
    end

    // frame stamp capture at delimiter
    if (sfd_pulse && s_r.ctrl[`CTRL_TSE]) begin
      s_nxt.fstamp = s_r.cnt;
    end
    // beacon stamp copy at frame end
    if (end_pulse && s_r.ctrl[`CTRL_TSE] && beacon_ok_r &&
        (src_id_r == s_r.netid || s_r.netid == `NETID_BCAST)) begin
      s_nxt.bstamp = s_r.fstamp;
    end
    // manual capture, self clearing
    if (s_r.ctrl[`CTRL_MANBCN]) begin
      s_nxt.bstamp = s_r.cnt;
      s_nxt.ctrl[`CTRL_MANBCN] = 1'b0;
    end
    // realign is a one-shot: clears prescaler and slot counter, then drops
    if (s_r.ctrl[`CTRL_REALIGN]) begin
      s_nxt.presc = 16'h0000;
      s_nxt.slot  = 5'h00;
      s_nxt.ctrl[`CTRL_REALIGN] = 1'b0;
    end

    // compare units: edge of equality so a held count does not refire
    for (int i = 0; i < 3; i++) begin
      hit[i] = s_r.ctrl[`CTRL_EN] &&
               (s_r.cnt == (s_r.ctrl[i] ? s_r.bstamp + s_r.match[i] : s_r.match[i]));
    end
    s_nxt.match_d = hit;
    evt[2:0] = hit & ~s_r.match_d;

    // write channel: takes address and data together, then answers
    if (wr_go) begin
      if (WSTRB[0]) begin
        unique case (widx)
          `IDX_CNT0: begin
            if (s_r.ctrl[`CTRL_EN]) begin
              s_nxt.cnt[7:0] = wb;
              s_nxt.pending  = 1'b1;
            end
          end
          `IDX_CNT1: s_nxt.cnt_stage[7:0]   = wb;
          `IDX_CNT2: s_nxt.cnt_stage[15:8]  = wb;
          `IDX_CNT3: s_nxt.cnt_stage[23:16] = wb;
          `IDX_BST0: s_nxt.bstamp = set_byte(s_r.bstamp, 2'd0, wb);
          `IDX_BST1: s_nxt.bstamp = set_byte(s_r.bstamp, 2'd1, wb);
          `IDX_BST2: s_nxt.bstamp = set_byte(s_r.bstamp, 2'd2, wb);
          `IDX_BST3: s_nxt.bstamp = set_byte(s_r.bstamp, 2'd3, wb);
          `IDX_M1B0: s_nxt.match[0] = set_byte(s_r.match[0], 2'd0, wb);
          `IDX_M1B1: s_nxt.match[0] = set_byte(s_r.match[0], 2'd1, wb);
          `IDX_M1B2: s_nxt.match[0] = set_byte(s_r.match[0], 2'd2, wb);
          `IDX_M1B3: s_nxt.match[0] = set_byte(s_r.match[0], 2'd3, wb);
          `IDX_CTRL: s_nxt.ctrl = wb;
          `IDX_IRQM: s_nxt.irqm = wb[4:0];
          `IDX_IRQS: s_nxt.irqs = s_r.irqs & ~wb[4:0];
          `IDX_NETID: s_nxt.netid = WDATA[15:0];
          default: begin
            if (widx >= `IDX_M2B0 && widx < `IDX_M2B0 + 8'h04)
              s_nxt.match[1] = set_byte(s_r.match[1], 2'(widx - `IDX_M2B0), wb);
            else if (widx >= `IDX_M3B0 && widx < `IDX_M3B0 + 8'h04)
              s_nxt.match[2] = set_byte(s_r.match[2], 2'(widx - `IDX_M3B0), wb);
            else if (!(widx inside {`IDX_FST0, `IDX_FST1, `IDX_FST2, `IDX_FST3, `IDX_STAT}))
              wr_ok = 1'b0;
          end
        endcase
      end
      s_nxt.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      s_nxt.wst   = symcnt_pkg::BUS_RESP;
    end else if (s_r.wst == symcnt_pkg::BUS_RESP && BREADY) begin
      s_nxt.wst = symcnt_pkg::BUS_IDLE;
    end

    // sticky status: a new event wins over a same-cycle clear
    s_nxt.irqs = s_nxt.irqs | evt;

    // read channel
    unique case (ridx)
      `IDX_CNT0: rd_word = {24'h0, byte_of(s_r.cnt, 2'd0)};
      `IDX_CNT1: rd_word = {24'h0, byte_of(s_r.cnt, 2'd1)};
      `IDX_CNT2: rd_word = {24'h0, byte_of(s_r.cnt, 2'd2)};
      `IDX_CNT3: rd_word = {24'h0, byte_of(s_r.cnt, 2'd3)};
      `IDX_FST0: rd_word = {24'h0, byte_of(s_r.fstamp, 2'd0)};
      `IDX_FST1: rd_word = {24'h0, byte_of(s_r.fstamp, 2'd1)};
      `IDX_FST2: rd_word = {24'h0, byte_of(s_r.fstamp, 2'd2)};
      `IDX_FST3: rd_word = {24'h0, byte_of(s_r.fstamp, 2'd3)};
      `IDX_BST0: rd_word = {24'h0, byte_of(s_r.bstamp, 2'd0)};
      `IDX_BST1: rd_word = {24'h0, byte_of(s_r.bstamp, 2'd1)};
      `IDX_BST2: rd_word = {24'h0, byte_of(s_r.bstamp, 2'd2)};
      `IDX_BST3: rd_word = {24'h0, byte_of(s_r.bstamp, 2'd3)};
      `IDX_M1B0: rd_word = {24'h0, byte_of(s_r.match[0], 2'd0)};
      `IDX_M1B1: rd_word = {24'h0, byte_of(s_r.match[0], 2'd1)};
      `IDX_M1B2: rd_word = {24'h0, byte_of(s_r.match[0], 2'd2)};
      `IDX_M1B3: rd_word = {24'h0, byte_of(s_r.match[0], 2'd3)};
      `IDX_CTRL: rd_word = {24'h0, s_r.ctrl};
      `IDX_STAT: rd_word = {31'h0, s_r.pending};
      `IDX_IRQS: rd_word = {27'h0, s_r.irqs};
      `IDX_IRQM: rd_word = {27'h0, s_r.irqm};
      `IDX_NETID: rd_word = {16'h0, s_r.netid};
      default: begin
        if (ridx >= `IDX_M2B0 && ridx < `IDX_M2B0 + 8'h04)
          rd_word = {24'h0, byte_of(s_r.match[1], 2'(ridx - `IDX_M2B0))};
        else if (ridx >= `IDX_M3B0 && ridx < `IDX_M3B0 + 8'h04)
          rd_word = {24'h0, byte_of(s_r.match[2], 2'(ridx - `IDX_M3B0))};
      end
    endcase
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_word;
      s_nxt.rresp  = `RESP_OKAY;
    end else if (s_r.rvalid && RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // single state register; reset gives zeros, broadcast net id and idle bus
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_r       <= '0;
      s_r.netid <= `NETID_BCAST;
      s_r.wst   <= symcnt_pkg::BUS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ready outputs combinational, valids and data from flops
  assign AWREADY = wr_go;
  assign WREADY  = wr_go;
  assign BVALID  = (s_r.wst == symcnt_pkg::BUS_RESP);
  assign BRESP   = s_r.bresp;
  assign ARREADY = rd_go;
  assign RVALID  = s_r.rvalid;
  assign RDATA   = s_r.rdata;
  assign RRESP   = s_r.rresp;
  assign IRQ     = |(s_r.irqs & s_r.irqm);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_wrap;
    @(posedge SYS_CLK) disable iff (RST)
    (s_r.ctrl[`CTRL_EN] && sym_tick && !s_r.pending && !cnt_wr && s_r.cnt == 32'hffff_ffff) |=> s_r.cnt == 32'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_inc;
    @(posedge SYS_CLK) disable iff (RST)
    (s_r.ctrl[`CTRL_EN] && sym_tick && !s_r.pending && !cnt_wr) |=> s_r.cnt == $past(s_r.cnt) + 32'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step");

  property p_realign;
    @(posedge SYS_CLK) disable iff (RST)
    s_r.ctrl[`CTRL_REALIGN] |=> (s_r.presc == 16'h0 && s_r.slot == 5'h0 && !s_r.ctrl[`CTRL_REALIGN]);
  endproperty
  a_realign: assert property (p_realign) else $error("realign failed");

  property p_manual;
    @(posedge SYS_CLK) disable iff (RST)
    s_r.ctrl[`CTRL_MANBCN] |=> (s_r.bstamp == $past(s_r.cnt) && !s_r.ctrl[`CTRL_MANBCN]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual capture failed");

  property p_sfd;
    @(posedge SYS_CLK) disable iff (RST)
    (sfd_pulse && s_r.ctrl[`CTRL_TSE]) |=> s_r.fstamp == $past(s_r.cnt);
  endproperty
  a_sfd: assert property (p_sfd) else $error("frame stamp not captured");

  property p_fst_ro;
    @(posedge SYS_CLK) disable iff (RST)
    !sfd_pulse |=> $stable(s_r.fstamp);
  endproperty
  a_fst_ro: assert property (p_fst_ro) else $error("frame stamp changed");

  property p_load;
    @(posedge SYS_CLK) disable iff (RST)
    (s_r.pending && s_r.ctrl[`CTRL_EN] && sym_tick && !cnt_wr)
      |=> (!s_r.pending && s_r.cnt[31:8] == $past(s_r.cnt_stage));
  endproperty
  a_load: assert property (p_load) else $error("staged count not loaded");

  property p_cmp;
    @(posedge SYS_CLK) disable iff (RST)
    (hit[0] && !s_r.match_d[0]) |=> s_r.irqs[0];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag missing");

  c_ovf: cover property (@(posedge SYS_CLK) disable iff (RST) evt[`IRQ_OVF]);
  c_beacon: cover property (@(posedge SYS_CLK) disable iff (RST) end_pulse && beacon_ok_r);
  c_irq: cover property (@(posedge SYS_CLK) disable iff (RST) IRQ);
  c_realign: cover property (@(posedge SYS_CLK) disable iff (RST) s_r.ctrl[`CTRL_REALIGN]);
  c_rel: cover property (@(posedge SYS_CLK) disable iff (RST) hit[1] && s_r.ctrl[1]);

  property p_ovf;
    @(posedge SYS_CLK) disable iff (RST)
    (s_r.ctrl[`CTRL_EN] && sym_tick && !s_r.pending && s_r.cnt == 32'hffff_ffff) |=> s_r.irqs[`IRQ_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing");

  // a disabled counter must not move, not even through a low byte write
  property p_frozen;
    @(posedge SYS_CLK) disable iff (RST)
    !s_r.ctrl[`CTRL_EN] |=> $stable(s_r.cnt);
  endproperty
  a_frozen: assert property (p_frozen) else $error("count moved while disabled");

  property p_pend;
    @(posedge SYS_CLK) disable iff (RST)
    (cnt_wr && s_r.ctrl[`CTRL_EN]) |=> s_r.pending;
  endproperty
  a_pend: assert property (p_pend) else $error("count load not pending");

  // manual capture and bus writes take priority over the copy, so they are left out
  property p_beacon;
    @(posedge SYS_CLK) disable iff (RST)
    (end_pulse && s_r.ctrl[`CTRL_TSE] && beacon_ok_r && src_id_r == s_r.netid &&
     !s_r.ctrl[`CTRL_MANBCN] && !wr_go) |=> s_r.bstamp == $past(s_r.fstamp);
  endproperty
  a_beacon: assert property (p_beacon) else $error("beacon stamp not copied");

  property p_rel;
    @(posedge SYS_CLK) disable iff (RST)
    (s_r.ctrl[`CTRL_EN] && s_r.ctrl[1] && !s_r.match_d[1] &&
     s_r.cnt == s_r.bstamp + s_r.match[1]) |=> s_r.irqs[1];
  endproperty
  a_rel: assert property (p_rel) else $error("relative match missing");

  ////////////////////////////////////////////////////////////////////////////
  // bus answers one cycle after the taking edge, one write at a time
  property p_wanswer;
    @(posedge SYS_CLK) disable iff (RST)
    wr_go |=> BVALID;
  endproperty
  a_wanswer: assert property (p_wanswer) else $error("write not answered");

  property p_ranswer;
    @(posedge SYS_CLK) disable iff (RST)
    rd_go |=> RVALID;
  endproperty
  a_ranswer: assert property (p_ranswer) else $error("read not answered");

  property p_one_wr;
    @(posedge SYS_CLK) disable iff (RST)
    BVALID |-> !AWREADY;
  endproperty
  a_one_wr: assert property (p_one_wr) else $error("write taken while response open");
endmodule

// File: test/rx_frame_model.sv
// partner model: receive-side source of delimiter, frame end and beacon indications
`timescale 1ns/1ps
module rx_frame_model (
  input  wire logic                 SYS_CLK, // system clock
  input  wire logic                 go,      // start one frame
  input  wire logic                 bcn,     // frame is a beacon with good check sequence
  input  wire logic [15:0]          src,     // source network id carried by the frame
  output symcnt_pkg::rx_evt_t       evt,     // events towards the counter
  output logic                      busy     // frame in progress
);
  logic [4:0] step;

  initial begin
    evt = '0;
    busy = 1'b0;
    step = 5'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // delimiter first, frame end later; id held well past the settle time of the
  // receiver, then scrambled so a late sampler cannot see a stale match
  always @(posedge SYS_CLK) begin
    if (go && !busy) begin
      busy <= 1'b1;
      step <= 5'h00;
      evt.sfd <= 1'b1;
    end else if (busy) begin
      step <= step + 5'h01;
      if (step == 5'h05) begin
        evt.sfd <= 1'b0;
        evt.frame_end <= 1'b1;
        evt.beacon_ok <= bcn;
        evt.src_id <= src;
      end
      if (step == 5'h0d) begin
        evt.frame_end <= 1'b0;
        evt.beacon_ok <= 1'b0;
        evt.src_id <= ~evt.src_id;
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: test/symbol_counter_test.sv
// self-checking bench for the symbol counter register block
`timescale 1ns/1ps
`include "symcnt_consts.svh"
module symbol_counter_test;
  localparam int PRESC = 4;
  typedef struct packed {
    logic [7:0] idx;
    logic       w;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] br;
  } row_t;
  logic                 SYS_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic                 ARVALID, ARREADY, RVALID, RREADY, IRQ, go, bcn, busy;
  logic [31:0]          AWADDR, WDATA, ARADDR, RDATA, d;
  logic [3:0]           WSTRB;
  logic [1:0]           BRESP, RRESP, r;
  logic [15:0]          src;
  logic [7:0]           c0;
  symcnt_pkg::rx_evt_t  evt;
  row_t                 rows[$];
  int                   fail_count, n_checks, cyc, t0;
  logic [7:0]           cnt_idx [4] = '{`IDX_CNT0, `IDX_CNT1, `IDX_CNT2, `IDX_CNT3};
  logic [15:0]          nid [4] = '{16'hffff, 16'h1234, 16'h1234, 16'h1234};
  logic [15:0]          sid [4] = '{16'h0777, 16'h1234, 16'h4321, 16'h1234};
  logic                 bk [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic                 cp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  symbol_counter #(.PRESC_CYC(PRESC)) i_dut (
    .SYS_CLK(SYS_CLK), .RST(RST), .RX_EVT(evt), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));

  rx_frame_model i_rx (.SYS_CLK(SYS_CLK), .go(go), .bcn(bcn), .src(src), .evt(evt), .busy(busy));

  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  //////////////////////////////////////////////////////////////////////////////
  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // bus tasks: ready and answers are looked at mid-cycle, where they are settled
  task automatic wr(input logic [7:0] idx, input logic [31:0] v);
    @(posedge SYS_CLK);
    AWADDR <= {22'h0, idx, 2'b00};
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do @(negedge SYS_CLK); while (AWREADY !== 1'b1);
    @(posedge SYS_CLK);
    AWVALID <= 1'b0;
    WVALID <= 1'b0;
    do @(negedge SYS_CLK); while (BVALID !== 1'b1);
    r = BRESP;
    @(posedge SYS_CLK);
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    @(posedge SYS_CLK);
    ARADDR <= {22'h0, idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(negedge SYS_CLK); while (ARREADY !== 1'b1);
    @(posedge SYS_CLK);
    ARVALID <= 1'b0;
    do @(negedge SYS_CLK); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    @(posedge SYS_CLK);
    RREADY <= 1'b0;
  endtask

  // a 32-bit value goes out high byte first, so the count loads only at the end
  task automatic wword(input logic [7:0] b0, input logic [31:0] v);
    for (int i = 3; i >= 0; i--) begin
      wr((b0 == `IDX_CNT0) ? cnt_idx[i] : b0 + 8'(i), {24'h0, v[8*i +: 8]});
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, go, bcn} = '0;
    {AWADDR, WDATA, ARADDR, src} = '0;
    WSTRB = 4'hf;
    RST = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rows.push_back('{cnt_idx[i], 1'b0, 8'h00, 8'h00, `RESP_OKAY});
      rows.push_back('{`IDX_FST0 + 8'(i), 1'b0, 8'h00, 8'h00, `RESP_OKAY});
      rows.push_back('{`IDX_BST0 + 8'(i), 1'b0, 8'h00, 8'h00, `RESP_OKAY});
      rows.push_back('{`IDX_M1B0 + 8'(i), 1'b0, 8'h00, 8'h00, `RESP_OKAY});
      rows.push_back('{`IDX_M1B0 + 8'(i), 1'b1, 8'h11 + 8'(i), 8'h11 + 8'(i), `RESP_OKAY});
      rows.push_back('{`IDX_M2B0 + 8'(i), 1'b1, 8'h21 + 8'(i), 8'h21 + 8'(i), `RESP_OKAY});
      rows.push_back('{`IDX_M3B0 + 8'(i), 1'b1, 8'h31 + 8'(i), 8'h31 + 8'(i), `RESP_OKAY});
      rows.push_back('{`IDX_BST0 + 8'(i), 1'b1, 8'h41 + 8'(i), 8'h41 + 8'(i), `RESP_OKAY});
    end
    rows.push_back('{`IDX_FST0, 1'b1, 8'h5a, 8'h00, `RESP_OKAY});
    rows.push_back('{8'h10, 1'b1, 8'h5a, 8'h00, `RESP_SLVERR});
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].idx, {24'h0, rows[k].d});
      if (rows[k].w) chk("write response", rows[k].br, r);
      rd(rows[k].idx);
      chk($sformatf("register %h", rows[k].idx), rows[k].e, d[7:0]);
      chk("read response", `RESP_OKAY, r);
    end
    // lane 0 strobe low: the byte write is dropped but still answered
    WSTRB <= 4'he;
    wr(`IDX_M1B0, 32'h99);
    chk("strobe response", `RESP_OKAY, r);
    WSTRB <= 4'hf;
    rd(`IDX_M1B0);
    chk("masked lane", 8'h11, d[7:0]);
    // compare: unit 2 relative to the beacon stamp, unit 1 absolute
    wword(`IDX_BST0, 32'h8);
    wword(`IDX_M1B0, 32'h10);
    wword(`IDX_M2B0, 32'h4);
    wword(`IDX_M3B0, 32'hffffffff);
    wr(`IDX_IRQS, 32'hff);
    wr(`IDX_IRQM, 32'h0);
    wr(`IDX_CTRL, 32'h22);
    d = '0;
    for (int i = 0; i < 100 && d[1] !== 1'b1; i++) rd(`IDX_IRQS);
    chk("unit 1 early", 1'b0, d[0]);
    rd(`IDX_CNT0);
    chk("relative hit", 1'b1, d[7:0] >= 8'h0c && d[7:0] <= 8'h0f);
    @(negedge SYS_CLK);
    chk("masked interrupt", 1'b0, IRQ);
    wr(`IDX_IRQM, 32'h1);
    for (int i = 0; i < 100 && IRQ !== 1'b1; i++) @(negedge SYS_CLK);
    chk("absolute interrupt", 1'b1, IRQ);
    wr(`IDX_IRQS, 32'h1);
    @(negedge SYS_CLK);
    chk("interrupt after clear", 1'b0, IRQ);
    // wrap through all-ones
    wword(`IDX_CNT0, 32'hffffffff);
    d = 32'h1;
    for (int i = 0; i < 50 && d[0] !== 1'b0; i++) rd(`IDX_STAT);
    d = '0;
    for (int i = 0; i < 100 && d[3] !== 1'b1; i++) rd(`IDX_IRQS);
    chk("overflow flag", 1'b1, d[3]);
    chk("unit 3 match", 1'b1, d[2]);
    wr(`IDX_CTRL, 32'h08);
    rd(`IDX_CNT3);
    chk("count top after wrap", 8'h00, d[7:0]);
    rd(`IDX_CNT0);
    c0 = d[7:0];
    chk("count low after wrap", 1'b1, c0 < 8'h20);
    // frames against a frozen count
    for (int k = 0; k < 4; k++) begin
      wr(`IDX_NETID, {16'h0, nid[k]});
      wr(`IDX_BST0, 32'haa);
      @(posedge SYS_CLK);
      go <= 1'b1;
      bcn <= bk[k];
      src <= sid[k];
      @(posedge SYS_CLK);
      go <= 1'b0;
      do @(negedge SYS_CLK); while (busy !== 1'b0);
      rd(`IDX_FST0);
      chk("frame stamp", c0, d[7:0]);
      rd(`IDX_BST0);
      chk("beacon stamp", cp[k] ? c0 : 8'haa, d[7:0]);
    end
    wr(`IDX_BST0, 32'haa);
    wr(`IDX_CTRL, 32'h48);
    rd(`IDX_BST0);
    chk("manual capture", c0, d[7:0]);
    rd(`IDX_CTRL);
    chk("manual bit self clear", 8'h08, d[7:0]);
    // realign gives a full backoff period of 20 symbols
    wr(`IDX_CTRL, 32'ha0);
    t0 = cyc;
    wr(`IDX_IRQS, 32'hff);
    wr(`IDX_IRQM, 32'h10);
    for (int i = 0; i < 200 && IRQ !== 1'b1; i++) @(negedge SYS_CLK);
    chk("backoff period", 1'b1, (cyc - t0) >= 74 && (cyc - t0) <= 86);
    // second reset in mid-run
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(negedge SYS_CLK);
    chk("interrupt after reset", 1'b0, IRQ);
    rd(`IDX_CNT0);
    chk("count after reset", 8'h00, d[7:0]);
    rd(`IDX_M1B0);
    chk("match after reset", 8'h00, d[7:0]);
    rd(`IDX_FST0);
    chk("stamp after reset", 8'h00, d[7:0]);
    close_out();
  end
endmodule
